// ===== design/nvw_pkg.sv
// Operation
// - Go needs key 0x55 then 0xAA first.
// - Key guards every erase and program.
// - Writes allowed only with guard bit set.
// - Hardware never clears the guard bit.
// - Clearing guard mid-cycle does not abort.
// - Go cannot set while guard clear.
// - Guard and go together start nothing.
// - Cycle end clears go, sets done.
// - Done flag stays until software clears.
// - Erase mode go erases addressed word.
// - Program mode go writes latched word.
// - Address captures table write address while idle.
// - Control 0x4004 selects one-word program.
// - Program cycle lasts 2 ms, no stall.
package nvw_pkg;
   // ****************************************
   // Register offsets.
   // ****************************************
   localparam logic [7:0] NVW_OFS_CONTROL = 8'h00;
   localparam logic [7:0] NVW_OFS_ADDRESS = 8'h04;
   localparam logic [7:0] NVW_OFS_KEY = 8'h08;
   localparam logic [7:0] NVW_OFS_STATUS = 8'h0C;
   localparam logic [7:0] NVW_OFS_LATCH = 8'h10;
   // ****************************************
   // Control fields and values.
   // ****************************************
   localparam int NVW_BIT_GO = 15;
   localparam int NVW_BIT_GUARD = 14;
   localparam int NVW_OP_LSB = 0;
   localparam int NVW_OP_W = 7;
   localparam logic [6:0] NVW_OP_WORD_PROGRAM = 7'h04;
   localparam logic [6:0] NVW_OP_WORD_ERASE = 7'h44;
   localparam logic [15:0] NVW_CTRL_PROGRAM_WORD = 16'h4004;
   localparam logic [7:0] NVW_KEY_FIRST = 8'h55;
   localparam logic [7:0] NVW_KEY_SECOND = 8'hAA;
   localparam logic [15:0] NVW_RST_CONTROL = 16'h0000;
   localparam logic [1:0] NVW_RESP_OKAY = 2'b00;
   localparam logic [1:0] NVW_RESP_SLVERR = 2'b10;
   // ****************************************
   // Timing.
   // ****************************************
   localparam int NVW_CLK_HZ = 10_000_000;
   localparam int NVW_CYCLE_US = 2000;
   localparam int NVW_CYCLE_CLKS = NVW_CYCLE_US * (NVW_CLK_HZ / 1_000_000);
   typedef enum logic [1:0] {NVW_KEY_IDLE, NVW_KEY_HALF, NVW_KEY_ARMED} nvw_key_t;
endpackage

// ===== design/nvw_controller.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
module nvw_controller
   import nvw_pkg::*;
#(
   parameter int CYCLE_CLKS = NVW_CYCLE_CLKS
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic table_write_low,
   input wire logic [23:0] table_write_address,
   input wire logic [15:0] table_write_data,
   output logic nvm_erase_strobe,
   output logic nvm_program_strobe,
   output logic [23:0] nvm_word_address,
   output logic [15:0] nvm_word_data,
   output logic nvm_busy
);
   // ****************************************
   // Write channel capture.
   // ****************************************
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_do;
   logic [15:0] nvm_control;
   logic [23:0] nvm_target_address;
   logic nvm_done_flag;
   nvw_key_t key_state;
   logic [31:0] cycle_count;
   logic [15:0] next_control;
   logic go_request;

   assign wr_do = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         s_axi_awready <= 1'b0;
      end
      else if (wr_do)
      begin
         aw_held <= 1'b0;
         s_axi_awready <= 1'b0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_wready <= 1'b0;
      end
      else if (wr_do)
      begin
         w_held <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_wready <= !w_held && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= NVW_RESP_OKAY;
      end
      else if (wr_do)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr == NVW_OFS_CONTROL || aw_addr == NVW_OFS_ADDRESS || aw_addr == NVW_OFS_KEY
                         || aw_addr == NVW_OFS_STATUS || aw_addr == NVW_OFS_LATCH) ? NVW_RESP_OKAY
                         : NVW_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // Control register and cycle start.
   // ****************************************
   always_comb
   begin
      next_control = nvm_control;
      if (w_strb[0])
      begin
         next_control[7:0] = w_data[7:0];
      end
      if (w_strb[1])
      begin
         next_control[15:8] = w_data[15:8];
      end
   end

   // Go is honoured only if guard was already set, keys armed and idle.
   assign go_request = wr_do && aw_addr == NVW_OFS_CONTROL && next_control[NVW_BIT_GO]
                       && !nvm_control[NVW_BIT_GO] && nvm_control[NVW_BIT_GUARD]
                       && key_state == NVW_KEY_ARMED;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         nvm_control <= NVW_RST_CONTROL;
      end
      else if (nvm_busy && cycle_count == 32'd1)
      begin
         nvm_control[NVW_BIT_GO] <= 1'b0;
         if (wr_do && aw_addr == NVW_OFS_CONTROL)
         begin
            nvm_control[NVW_BIT_GUARD] <= next_control[NVW_BIT_GUARD];
         end
      end
      else if (wr_do && aw_addr == NVW_OFS_CONTROL)
      begin
         // Guard changes only by software; op select frozen while busy.
         nvm_control[NVW_BIT_GUARD] <= next_control[NVW_BIT_GUARD];
         if (!nvm_busy)
         begin
            nvm_control[NVW_BIT_GO] <= go_request;
            nvm_control[NVW_OP_W - 1:NVW_OP_LSB] <= next_control[NVW_OP_W - 1:NVW_OP_LSB];
            nvm_control[13:NVW_OP_W] <= next_control[13:NVW_OP_W];
         end
      end
   end

   // ****************************************
   // Unlock key sequence.
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         key_state <= NVW_KEY_IDLE;
      end
      else if (wr_do)
      begin
         if (aw_addr == NVW_OFS_KEY && w_data[7:0] == NVW_KEY_FIRST)
         begin
            key_state <= NVW_KEY_HALF;
         end
         else if (aw_addr == NVW_OFS_KEY && w_data[7:0] == NVW_KEY_SECOND && key_state == NVW_KEY_HALF)
         begin
            key_state <= NVW_KEY_ARMED;
         end
         else if (key_state == NVW_KEY_ARMED && aw_addr == NVW_OFS_CONTROL && !go_request)
         begin
            key_state <= NVW_KEY_ARMED;
         end
         else
         begin
            key_state <= NVW_KEY_IDLE;
         end
      end
   end

   // ****************************************
   // Address capture and cycle timer.
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         nvm_target_address <= 24'h00_0000;
         nvm_word_data <= 16'h0000;
      end
      else if (table_write_low && !nvm_busy)
      begin
         nvm_target_address <= table_write_address;
         nvm_word_data <= table_write_data;
      end
      else if (wr_do && !nvm_busy && aw_addr == NVW_OFS_ADDRESS)
      begin
         nvm_target_address <= w_data[23:0];
      end
      else if (wr_do && !nvm_busy && aw_addr == NVW_OFS_LATCH)
      begin
         nvm_word_data <= w_data[15:0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         nvm_busy <= 1'b0;
         cycle_count <= 32'd0;
         nvm_erase_strobe <= 1'b0;
         nvm_program_strobe <= 1'b0;
         nvm_word_address <= 24'h00_0000;
      end
      else
      begin
         nvm_erase_strobe <= go_request && next_control[NVW_OP_W - 1:0] == NVW_OP_WORD_ERASE;
         nvm_program_strobe <= go_request && next_control[NVW_OP_W - 1:0] == NVW_OP_WORD_PROGRAM;
         if (go_request)
         begin
            nvm_busy <= 1'b1;
            cycle_count <= CYCLE_CLKS;
            nvm_word_address <= nvm_target_address;
         end
         else if (nvm_busy)
         begin
            cycle_count <= cycle_count - 32'd1;
            nvm_busy <= cycle_count != 32'd1;
         end
      end
   end

   // ****************************************
   // Completion flag.
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         nvm_done_flag <= 1'b0;
      end
      else if (nvm_busy && cycle_count == 32'd1)
      begin
         nvm_done_flag <= 1'b1;
      end
      else if (wr_do && aw_addr == NVW_OFS_STATUS && w_strb[0] && w_data[0])
      begin
         nvm_done_flag <= 1'b0;
      end
   end

   // ****************************************
   // Read channel.
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= NVW_RESP_OKAY;
      end
      else if (s_axi_rvalid)
      begin
         s_axi_rvalid <= !s_axi_rready;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= NVW_RESP_OKAY;
         unique case (s_axi_araddr)
            NVW_OFS_CONTROL: s_axi_rdata <= {16'h0000, nvm_control};
            NVW_OFS_ADDRESS: s_axi_rdata <= {8'h00, nvm_target_address};
            NVW_OFS_KEY: s_axi_rdata <= 32'h0000_0000;
            NVW_OFS_STATUS: s_axi_rdata <= {30'h0000_0000, nvm_busy, nvm_done_flag};
            NVW_OFS_LATCH: s_axi_rdata <= {16'h0000, nvm_word_data};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= NVW_RESP_SLVERR;
            end
         endcase
      end
      else
      begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// ===== tb/nvw_controller_chk.sv
module nvw_controller_chk
#(
   parameter int CYCLE_CLKS = 20
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic nvm_erase_strobe,
   input wire logic nvm_program_strobe,
   input wire logic [23:0] nvm_word_address,
   input wire logic [15:0] nvm_word_data,
   input wire logic nvm_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [15:0] cnt;
   sequence start_s;
      nvm_erase_strobe || nvm_program_strobe;
   endsequence
   sequence b_wait_s;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   always_ff @(posedge aclk)
      cnt <= (aresetn && nvm_busy) ? cnt + 16'h0001 : 16'h0000;
   strobe_pulse_a: assert property (start_s |=> !nvm_erase_strobe && !nvm_program_strobe)
      else $error("start strobe longer than one cycle");
   start_busy_a: assert property (start_s |-> nvm_busy && !$past(nvm_busy))
      else $error("start strobe without fresh busy");
   busy_cause_a: assert property ($rose(nvm_busy) |-> start_s ##0 s_axi_bvalid)
      else $error("busy rose without a write");
   busy_len_a: assert property ($fell(nvm_busy) && $past(aresetn) |-> cnt == CYCLE_CLKS)
      else $error("cycle length wrong");
   busy_max_a: assert property (nvm_busy |-> cnt < CYCLE_CLKS)
      else $error("cycle runs too long");
   one_kind_a: assert property (!(nvm_erase_strobe && nvm_program_strobe))
      else $error("erase and program together");
   hold_target_a: assert property (nvm_busy && $past(nvm_busy)
      |-> $stable(nvm_word_address) && $stable(nvm_word_data))
      else $error("target moved during cycle");
   bresp_hold_a: assert property (b_wait_s |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule
bind nvw_controller nvw_controller_chk #(.CYCLE_CLKS(CYCLE_CLKS)) chk_u (.*);

// ===== tb/nvw_controller_test.sv
module nvw_controller_test
   import nvw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} nvw_row_t;
   typedef struct {logic [31:0] pre; logic [7:0] k1; logic [7:0] k2; logic [31:0] go;} nvw_try_t;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, table_write_low = 0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
   logic [23:0] table_write_address = 24'h00_0000, nvm_word_address, tgt;
   logic [15:0] table_write_data = 16'h0000, nvm_word_data, dat;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic nvm_erase_strobe, nvm_program_strobe, nvm_busy;
   int bad_count = 0, comparisons = 0, cyc = 0, n_erase = 0, n_prog = 0;
   nvw_row_t rows [4] = '{'{NVW_OFS_CONTROL, 32'h0000_4004, 32'h0000_4004, NVW_RESP_OKAY},
      '{NVW_OFS_ADDRESS, 32'h0012_3456, 32'h0012_3456, NVW_RESP_OKAY},
      '{NVW_OFS_LATCH, 32'h0000_BEEF, 32'h0000_BEEF, NVW_RESP_OKAY},
      '{8'h14, 32'h0000_1234, 32'h0000_0000, NVW_RESP_SLVERR}};
   nvw_try_t tries [4] = '{'{32'h0000_0044, 8'h55, 8'hAA, 32'h0000_8044},
      '{32'h0000_0044, 8'h55, 8'hAA, 32'h0000_C044},
      '{32'h0000_4044, 8'hAA, 8'h55, 32'h0000_C044},
      '{32'h0000_4044, 8'h55, 8'h55, 32'h0000_C044}};
   nvw_controller #(.CYCLE_CLKS(20)) dut_u (.*);
   // ****************************************
   // Clock, monitor and checks.
   // ****************************************
   initial forever #50 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (nvm_erase_strobe === 1'b1) n_erase <= n_erase + 1;
      if (nvm_program_strobe === 1'b1) n_prog <= n_prog + 1;
      if (nvm_busy === 1'b1) tgt <= nvm_word_address;
      if (nvm_busy === 1'b1) dat <= nvm_word_data;
      if (cyc == 5000)
      begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
      wr(NVW_OFS_KEY, {24'h00_0000, k1});
      wr(NVW_OFS_KEY, {24'h00_0000, k2});
   endtask
   task automatic settle();
      while (nvm_busy) @(posedge aclk);
      @(posedge aclk);
   endtask
   // ****************************************
   // Main sequence.
   // ****************************************
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(NVW_OFS_CONTROL);
      chk(rd, {16'h0000, NVW_RST_CONTROL});
      rdr(NVW_OFS_STATUS);
      chk(rd, 32'h0000_0000);
      $display("reset test done");
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         chk(32'(resp), 32'(rows[i].r));
         rdr(rows[i].a);
         chk(rd, rows[i].q);
         chk(32'(resp), 32'(rows[i].r));
      end
      $display("register test done");
      table_write_address <= 24'h00_0ABC;
      table_write_data <= 16'h1234;
      table_write_low <= 1'b1;
      @(posedge aclk);
      table_write_low <= 1'b0;
      keys(NVW_KEY_FIRST, NVW_KEY_SECOND);
      wr(NVW_OFS_CONTROL, {16'h0000, NVW_CTRL_PROGRAM_WORD | 16'h8000});
      settle();
      chk(32'(n_prog), 32'h0000_0001);
      chk({8'h00, tgt}, 32'h0000_0ABC);
      chk({16'h0000, dat}, 32'h0000_1234);
      rdr(NVW_OFS_CONTROL);
      chk(rd, 32'h0000_4004);
      rdr(NVW_OFS_STATUS);
      chk(rd, 32'h0000_0001);
      rdr(NVW_OFS_STATUS);
      chk(rd, 32'h0000_0001);
      wr(NVW_OFS_STATUS, 32'h0000_0001);
      rdr(NVW_OFS_STATUS);
      chk(rd, 32'h0000_0000);
      $display("program test done");
      wr(NVW_OFS_CONTROL, 32'h0000_4044);
      wr(NVW_OFS_ADDRESS, 32'h0000_0200);
      keys(NVW_KEY_FIRST, NVW_KEY_SECOND);
      wr(NVW_OFS_CONTROL, 32'h0000_C044);
      wr(NVW_OFS_CONTROL, 32'h0000_8044);
      rdr(NVW_OFS_CONTROL);
      chk(rd, 32'h0000_8044);
      rdr(NVW_OFS_STATUS);
      chk(rd, 32'h0000_0002);
      settle();
      chk(32'(n_erase), 32'h0000_0001);
      chk({8'h00, tgt}, 32'h0000_0200);
      rdr(NVW_OFS_CONTROL);
      chk(rd, 32'h0000_0044);
      $display("erase test done");
      foreach (tries[i])
      begin
         wr(NVW_OFS_CONTROL, tries[i].pre);
         keys(tries[i].k1, tries[i].k2);
         wr(NVW_OFS_CONTROL, tries[i].go);
         settle();
         chk(32'(n_erase), 32'h0000_0001);
      end
      wr(NVW_OFS_CONTROL, 32'h0000_4044);
      wr(NVW_OFS_KEY, 32'h0000_0055);
      wr(NVW_OFS_ADDRESS, 32'h0000_0300);
      wr(NVW_OFS_KEY, 32'h0000_00AA);
      wr(NVW_OFS_CONTROL, 32'h0000_C044);
      settle();
      chk(32'(n_erase), 32'h0000_0001);
      keys(NVW_KEY_FIRST, NVW_KEY_SECOND);
      wr(NVW_OFS_CONTROL, 32'h0000_C044);
      settle();
      chk(32'(n_erase), 32'h0000_0002);
      chk({8'h00, tgt}, 32'h0000_0300);
      $display("refusal test done");
      keys(NVW_KEY_FIRST, NVW_KEY_SECOND);
      wr(NVW_OFS_CONTROL, 32'h0000_C044);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(NVW_OFS_STATUS);
      chk(rd, 32'h0000_0000);
      rdr(NVW_OFS_CONTROL);
      chk(rd, {16'h0000, NVW_RST_CONTROL});
      chk(32'(n_erase), 32'h0000_0003);
      $display("mid-run reset test done");
      report_and_stop();
   end
endmodule
